//--- rtl/virt_capability_msr_bank.sv
// Virtualization capability register bank with guest entry checks
`timescale 1ns/1ps
`default_nettype none

module virt_capability_msr_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Model register access
  input wire logic msr_rd_req,
  input wire logic msr_wr_req,
  input wire logic [31:0] msr_index,
  input wire logic system_management_mode,
  input wire logic [63:0] smbase_value,
  output logic [63:0] msr_rd_data,
  output logic msr_ack,
  output logic msr_fault,
  // Guest entry check
  input wire logic entry_req,
  input wire logic [31:0] entry_ctls,
  input wire logic [31:0] prim_exit_ctls,
  input wire logic [63:0] sec_exit_ctls,
  input wire logic [1:0] activity_state,
  input wire logic inj_valid,
  input wire logic [2:0] inj_type,
  input wire logic [3:0] inj_len,
  output logic entry_done,
  output logic entry_fail,
  // Preemption timer rate
  input wire logic [63:0] timestamp_counter,
  input wire logic preempt_timer_active,
  output logic preempt_tick,
  // Guest exit store
  input wire logic guest_exit,
  input wire logic long_mode_active_flag,
  output logic guest64_entry_ctl,
  // Operation entry and leave
  input wire logic enter_virt_operation,
  input wire logic leave_virt_operation,
  input wire logic trace_ctl_write,
  input wire logic smm_monitor_ctl_bit2,
  output logic trace_enable_clear,
  output logic trace_write_fault,
  output logic smi_unblock,
  // Structure field write
  input wire logic field_write_req,
  input wire logic [31:0] field_encoding,
  output logic field_write_done,
  output logic field_write_fail
);

  import virt_cap_pkg::*;

  // Whole block state
  typedef struct packed {
    logic [63:0] rd_data;
    logic ack;
    logic fault;
    logic e_done;
    logic e_fail;
    logic tsc_prev;
    logic tick;
    logic guest64;
    logic in_virt_op;
    logic trace_clr;
    logic trace_fault;
    logic smi_unblk;
    logic f_done;
    logic f_fail;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;

  // Shorthand for the constant miscellaneous register
  localparam logic [63:0] MISC = MISC_VIRT_CAP_VAL;

  // Low half seen by software: default-one bits always read as one
  localparam logic [63:0] ENTRY_CAP_RD =
    ENTRY_CTL_CAP_VAL | {32'h0, ENTRY_DEFAULT_ONE};

  // Effective entry capability, chosen once by the true-controls bit
  logic [31:0] entry_must_one;
  logic [31:0] entry_may_one;
  logic entry_ctl_bad;
  logic sec_exit_bad;
  logic act_bad;
  logic inj_bad;
  logic tsc_bit;
  logic [8:0] max_index;
  logic trace_forbidden;

  // Pick the register that holds the full allowed settings
  always_comb
  begin
    if (BASIC_TRUE_CTLS_BIT55)
    begin
      // True register: no exceptions for default-one bits
      entry_must_one = TRUE_ENTRY_CTL_VAL[31:0];
      entry_may_one = TRUE_ENTRY_CTL_VAL[63:32];
    end
    else
    begin
      // Default-one bits are forced one here
      entry_must_one = ENTRY_CAP_RD[31:0];
      entry_may_one = ENTRY_CAP_RD[63:32];
    end
  end

  // Entry controls against both capability halves
  allowed_ctl_check #(
    .W(32)
  ) u_entry_check (
    .ctl(entry_ctls),
    .must_one(entry_must_one),
    .may_one(entry_may_one),
    .enable(1'b1),
    .fail(entry_ctl_bad)
  );

  // Secondary exit controls apply only with the activate bit set
  allowed_ctl_check #(
    .W(64)
  ) u_sec_exit_check (
    .ctl(sec_exit_ctls),
    .must_one(64'h0),
    .may_one(PRIM_EXIT_ACT2_BIT63 ? SEC_EXIT_CTL_VAL : 64'h0),
    .enable(prim_exit_ctls[EXIT_ACT2_BIT]),
    .fail(sec_exit_bad)
  );

  // Activity state and injection checks
  always_comb
  begin
    // State 0 always allowed; others need their bitmap bit
    act_bad = 1'b0;
    if (activity_state != 2'h0)
    begin
      act_bad = !MISC[MISC_ACT_LSB + int'(activity_state) - 1];
    end
    // Zero-length software events need explicit support
    inj_bad = inj_valid && (inj_len == 4'h0) && !MISC[MISC_ZERO_LEN] &&
      (inj_type == INJ_SW_INT || inj_type == INJ_PRIV_SW_EXC ||
       inj_type == INJ_SW_EXC);
  end

  // Timer source bit and derived limits
  always_comb
  begin
    tsc_bit = timestamp_counter[MISC[MISC_RATE_LSB +: 5]];
    max_index = FIELD_ENUM_VAL[ENC_INDEX_LSB +: 9];
    trace_forbidden = TRACE_PRESENT && !MISC[MISC_TRACE_OK];
  end

  // Next state of the whole block
  always_comb
  begin
    next_st = st;
    // Pulses last a single cycle
    next_st.ack = 1'b0;
    next_st.fault = 1'b0;
    next_st.e_done = 1'b0;
    next_st.e_fail = 1'b0;
    next_st.tick = 1'b0;
    next_st.trace_clr = 1'b0;
    next_st.trace_fault = 1'b0;
    next_st.smi_unblk = 1'b0;
    next_st.f_done = 1'b0;
    next_st.f_fail = 1'b0;

    // Register reads; data holds until the next answered read
    if (msr_wr_req)
    begin
      // Whole bank is read-only, so every write faults
      next_st.fault = 1'b1;
    end
    else if (msr_rd_req)
    begin
      next_st.ack = 1'b1;
      unique case (msr_index)
        ENTRY_CTL_CAPABILITY_IDX: next_st.rd_data = ENTRY_CAP_RD;
        MISC_VIRT_CAPABILITY_IDX: next_st.rd_data = MISC;
        CTRL_REG0_FIXED_ZERO_IDX: next_st.rd_data = CR0_FIXED_ZERO_VAL;
        CTRL_REG0_FIXED_ONE_IDX: next_st.rd_data = CR0_FIXED_ONE_VAL;
        CTRL_REG4_FIXED_ZERO_IDX: next_st.rd_data = CR4_FIXED_ZERO_VAL;
        CTRL_REG4_FIXED_ONE_IDX: next_st.rd_data = CR4_FIXED_ONE_VAL;
        FIELD_ENUMERATION_IDX: next_st.rd_data = FIELD_ENUM_VAL;
        TRUE_ENTRY_CTL_IDX:
        begin
          // Absent without the true-controls bit
          if (BASIC_TRUE_CTLS_BIT55)
            next_st.rd_data = TRUE_ENTRY_CTL_VAL;
          else
          begin
            next_st.ack = 1'b0;
            next_st.fault = 1'b1;
          end
        end
        SECONDARY_EXIT_CTL_IDX:
        begin
          // Absent unless the activate exit control may be set
          if (PRIM_EXIT_ACT2_BIT63)
            next_st.rd_data = SEC_EXIT_CTL_VAL;
          else
          begin
            next_st.ack = 1'b0;
            next_st.fault = 1'b1;
          end
        end
        SYS_MGMT_BASE_IDX:
        begin
          // Visible only inside management mode and only if allowed
          if (system_management_mode && MISC[MISC_SMBASE_RD])
            next_st.rd_data = smbase_value;
          else
          begin
            next_st.ack = 1'b0;
            next_st.fault = 1'b1;
          end
        end
        default:
        begin
          // Unknown index: fault, data kept
          next_st.ack = 1'b0;
          next_st.fault = 1'b1;
        end
      endcase
    end

    // Guest entry verdict, one cycle after the request
    if (entry_req)
    begin
      next_st.e_done = 1'b1;
      next_st.e_fail = entry_ctl_bad || sec_exit_bad || act_bad ||
        inj_bad;
    end

    // Timer tick on every change of the selected counter bit while the timer is active
    next_st.tsc_prev = tsc_bit;
    next_st.tick = preempt_timer_active && (tsc_bit != st.tsc_prev);

    // Exit stores the long mode flag into the entry control copy
    if (guest_exit && MISC[MISC_STORE_LMA])
      next_st.guest64 = long_mode_active_flag;

    // Entering and leaving operation
    if (enter_virt_operation)
    begin
      next_st.in_virt_op = 1'b1;
      next_st.trace_clr = trace_forbidden;
    end
    else if (leave_virt_operation && st.in_virt_op)
    begin
      next_st.in_virt_op = 1'b0;
      // Monitor bit counts only where it can be set at all
      next_st.smi_unblk =
        !(MISC[MISC_SMM_CTL2] && smm_monitor_ctl_bit2);
    end

    // Trace control writes fault while in operation if trace is barred from it
    if (trace_ctl_write && st.in_virt_op && trace_forbidden)
      next_st.trace_fault = 1'b1;

    // Structure field write: encoding layout and exit info guard
    if (field_write_req)
    begin
      next_st.f_done = 1'b1;
      next_st.f_fail = |(field_encoding & ENC_RESERVED_MASK) ||
        (field_encoding[ENC_INDEX_LSB +: 9] > max_index) ||
        (field_encoding[ENC_TYPE_LSB +: 2] == ENC_TYPE_EXIT_INFO &&
         !MISC[MISC_ANY_WRITE]);
    end
  end

  // State register; synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  // Outputs straight from the state
  assign msr_rd_data = st.rd_data;
  assign msr_ack = st.ack;
  assign msr_fault = st.fault;
  assign entry_done = st.e_done;
  assign entry_fail = st.e_fail;
  assign preempt_tick = st.tick;
  assign guest64_entry_ctl = st.guest64;
  assign trace_enable_clear = st.trace_clr;
  assign trace_write_fault = st.trace_fault;
  assign smi_unblock = st.smi_unblk;
  assign field_write_done = st.f_done;
  assign field_write_fail = st.f_fail;

  // Checks on the block's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // A read request of a mapped index
  sequence s_misc_read;
    msr_rd_req && !msr_wr_req && msr_index == MISC_VIRT_CAPABILITY_IDX;
  endsequence

  sequence s_ack_misc;
    msr_ack && msr_rd_data == MISC;
  endsequence

  a_write_rejected: assert property (
    msr_wr_req |=> msr_fault && !msr_ack)
    else $error("write to capability bank not faulted");

  a_misc_readback: assert property (
    s_misc_read |=> s_ack_misc ##1 (msr_rd_data[31] == 1'b0 &&
      msr_rd_data[13:9] == 5'h0))
    else $error("miscellaneous read wrong");

  a_entry_default_one: assert property (
    msr_rd_req && !msr_wr_req && msr_index == ENTRY_CTL_CAPABILITY_IDX
    |=> msr_ack && &msr_rd_data[8:0] && msr_rd_data[12])
    else $error("default-one entry bits not read as one");

  a_entry_must_one: assert property (
    entry_req && |(entry_must_one & ~entry_ctls) |=> entry_done && entry_fail)
    else $error("forced entry control zero not failed");

  a_entry_may_one: assert property (
    entry_req && |(entry_ctls & ~entry_may_one) |=> entry_fail)
    else $error("disallowed entry control one not failed");

  a_sec_exit_fail: assert property (
    entry_req && prim_exit_ctls[EXIT_ACT2_BIT] &&
    |(sec_exit_ctls & ~SEC_EXIT_CTL_VAL) |=> entry_fail)
    else $error("secondary exit control not checked");

  a_active_state_ok: assert property (
    entry_req && activity_state == 2'h0 && !entry_ctl_bad && !sec_exit_bad
    && !inj_bad |=> entry_done && !entry_fail)
    else $error("active state entry refused");

  a_timer_tick: assert property (
    preempt_timer_active && $changed(tsc_bit) |=> preempt_tick)
    else $error("preemption tick missed");

  a_tick_cause: assert property (
    preempt_tick |-> $past(preempt_timer_active))
    else $error("tick while timer inactive");

  a_exit_store: assert property (
    guest_exit |=> guest64_entry_ctl == $past(long_mode_active_flag))
    else $error("long mode flag not stored on exit");

  // Clear pulse only where trace exists but is barred from operation
  a_trace_clear: assert property (
    enter_virt_operation |=>
      trace_enable_clear == (TRACE_PRESENT && !MISC[MISC_TRACE_OK]))
    else $error("trace enable clear wrong on entering");

  a_smi_unblock: assert property (
    leave_virt_operation && !enter_virt_operation && st.in_virt_op &&
    !smm_monitor_ctl_bit2 |=> smi_unblock)
    else $error("interrupts not unblocked on leaving");

  a_reserved_enc_bit: assert property (
    field_write_req && field_encoding[12] |=> field_write_fail)
    else $error("reserved encoding bit accepted");

  // Well-formed exit information write fails only without bit 29
  a_exit_info_write: assert property (
    field_write_req && field_encoding[ENC_TYPE_LSB +: 2] == ENC_TYPE_EXIT_INFO
    && (field_encoding & ENC_RESERVED_MASK) == 32'h0 &&
    field_encoding[ENC_INDEX_LSB +: 9] <= max_index
    |=> field_write_done && field_write_fail == !MISC[MISC_ANY_WRITE])
    else $error("exit information write guard wrong");

  a_target_count: assert property (
    MISC[MISC_TGT_TOP] == (MISC[MISC_TGT_LSB +: 8] == 8'h0))
    else $error("target count field inconsistent");

  a_fixed_pairs: assert property (
    (CR0_FIXED_ZERO_VAL & ~CR0_FIXED_ONE_VAL) == 64'h0 &&
    (CR4_FIXED_ZERO_VAL & ~CR4_FIXED_ONE_VAL) == 64'h0)
    else $error("fixed-zero mask exceeds fixed-one mask");

  a_smbase_gate: assert property (
    msr_rd_req && !msr_wr_req && msr_index == SYS_MGMT_BASE_IDX &&
    !system_management_mode |=> msr_fault)
    else $error("base register read outside management mode");

endmodule

`default_nettype wire

//--- rtl/virt_cap_pkg.sv
// Package with capability register offsets, fixed contents and field layouts
package virt_cap_pkg;

  // Model register indices of the capability bank
  localparam logic [31:0] ENTRY_CTL_CAPABILITY_IDX = 32'h0000_0484;
  localparam logic [31:0] MISC_VIRT_CAPABILITY_IDX = 32'h0000_0485;
  localparam logic [31:0] CTRL_REG0_FIXED_ZERO_IDX = 32'h0000_0486;
  localparam logic [31:0] CTRL_REG0_FIXED_ONE_IDX = 32'h0000_0487;
  localparam logic [31:0] CTRL_REG4_FIXED_ZERO_IDX = 32'h0000_0488;
  localparam logic [31:0] CTRL_REG4_FIXED_ONE_IDX = 32'h0000_0489;
  localparam logic [31:0] FIELD_ENUMERATION_IDX = 32'h0000_048a;
  localparam logic [31:0] TRUE_ENTRY_CTL_IDX = 32'h0000_0490;
  localparam logic [31:0] SECONDARY_EXIT_CTL_IDX = 32'h0000_0493;
  localparam logic [31:0] SYS_MGMT_BASE_IDX = 32'h0000_009e;

  // Capability bits of registers outside this bank
  localparam logic BASIC_TRUE_CTLS_BIT55 = 1'b1;
  localparam logic PRIM_EXIT_ACT2_BIT63 = 1'b1;
  localparam logic TRACE_PRESENT = 1'b1;

  // Fixed contents of the bank
  localparam logic [63:0] ENTRY_CTL_CAP_VAL = 64'h0003_ffff_0000_11ff;
  localparam logic [63:0] TRUE_ENTRY_CTL_VAL = 64'h0003_ffff_0000_0004;
  localparam logic [63:0] SEC_EXIT_CTL_VAL = 64'h0000_0000_0000_000f;
  localparam logic [63:0] MISC_VIRT_CAP_VAL = 64'h0000_0000_7004_c1e5;
  localparam logic [63:0] CR0_FIXED_ZERO_VAL = 64'h0000_0000_8000_0021;
  localparam logic [63:0] CR0_FIXED_ONE_VAL = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] CR4_FIXED_ZERO_VAL = 64'h0000_0000_0000_2000;
  localparam logic [63:0] CR4_FIXED_ONE_VAL = 64'h0000_0000_003f_f7ff;
  localparam logic [63:0] FIELD_ENUM_VAL = 64'h0000_0000_0000_0054;

  // Entry controls of the default-one class
  localparam logic [31:0] ENTRY_DEFAULT_ONE = 32'h0000_11ff;

  // Miscellaneous register field positions
  localparam int MISC_RATE_LSB = 0;
  localparam int MISC_STORE_LMA = 5;
  localparam int MISC_ACT_LSB = 6;
  localparam int MISC_TRACE_OK = 14;
  localparam int MISC_SMBASE_RD = 15;
  localparam int MISC_TGT_LSB = 16;
  localparam int MISC_TGT_TOP = 24;
  localparam int MISC_LIST_LSB = 25;
  localparam int MISC_SMM_CTL2 = 28;
  localparam int MISC_ANY_WRITE = 29;
  localparam int MISC_ZERO_LEN = 30;
  localparam int MISC_REV_LSB = 32;

  // Field encoding layout
  localparam int ENC_WIDTH_LSB = 13;
  localparam int ENC_TYPE_LSB = 10;
  localparam int ENC_INDEX_LSB = 1;
  localparam logic [1:0] ENC_TYPE_EXIT_INFO = 2'h1;
  localparam logic [31:0] ENC_RESERVED_MASK = 32'hffff_9000;

  // Control bit positions and injection kinds
  localparam int EXIT_ACT2_BIT = 31;
  localparam logic [2:0] INJ_SW_INT = 3'h4;
  localparam logic [2:0] INJ_PRIV_SW_EXC = 3'h5;
  localparam logic [2:0] INJ_SW_EXC = 3'h6;

endpackage

//--- rtl/allowed_ctl_check.sv
// Allowed-setting check of one control word against its capability halves
`timescale 1ns/1ps
`default_nettype none

module allowed_ctl_check #(
  parameter int W = 32
) (
  // Control word under test
  input wire logic [W-1:0] ctl,
  // Bits that must be one
  input wire logic [W-1:0] must_one,
  // Bits that may be one
  input wire logic [W-1:0] may_one,
  // Check applies only while enabled
  input wire logic enable,
  // Entry must fail
  output logic fail
);

  // Pure combination: a zero where a one is forced, or a one not allowed
  always_comb
  begin
    fail = enable && (|(must_one & ~ctl) || |(ctl & ~may_one));
  end

endmodule

`default_nettype wire

//--- tb/virt_capability_msr_bank_bench.sv
// Self-checking bench for the virtualization capability register bank
`timescale 1ns/1ps
`default_nettype none

module virt_capability_msr_bank_bench;
  import virt_cap_pkg::*;

  // Clock, reset and register access inputs
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic msr_rd_req = 1'b0, msr_wr_req = 1'b0, system_management_mode = 1'b0;
  logic [31:0] msr_index = 32'h0;
  logic [63:0] smbase_value = 64'h0123_4567_89ab_cdef;
  // Entry check inputs
  logic entry_req = 1'b0, inj_valid = 1'b0;
  logic [31:0] entry_ctls = 32'h0, prim_exit_ctls = 32'h0;
  logic [63:0] sec_exit_ctls = 64'h0, timestamp_counter = 64'h0;
  logic [1:0] activity_state = 2'h0;
  logic [2:0] inj_type = 3'h0;
  logic [3:0] inj_len = 4'h0;
  // Timer, exit, operation and field write inputs
  logic preempt_timer_active = 1'b0, guest_exit = 1'b0;
  logic long_mode_active_flag = 1'b0, enter_virt_operation = 1'b0;
  logic leave_virt_operation = 1'b0, trace_ctl_write = 1'b0;
  logic smm_monitor_ctl_bit2 = 1'b0, field_write_req = 1'b0;
  logic [31:0] field_encoding = 32'h0;
  // Design outputs
  logic [63:0] msr_rd_data;
  logic msr_ack, msr_fault, entry_done, entry_fail, preempt_tick;
  logic guest64_entry_ctl, trace_enable_clear, trace_write_fault;
  logic smi_unblock, field_write_done, field_write_fail;
  // Bookkeeping
  int fail_count = 0;
  int check_count = 0;
  int tick_count = 0;

  virt_capability_msr_bank dut (
    .core_clk(core_clk), .reset(reset), .msr_rd_req(msr_rd_req),
    .msr_wr_req(msr_wr_req), .msr_index(msr_index),
    .system_management_mode(system_management_mode),
    .smbase_value(smbase_value), .msr_rd_data(msr_rd_data),
    .msr_ack(msr_ack), .msr_fault(msr_fault), .entry_req(entry_req),
    .entry_ctls(entry_ctls), .prim_exit_ctls(prim_exit_ctls),
    .sec_exit_ctls(sec_exit_ctls), .activity_state(activity_state),
    .inj_valid(inj_valid), .inj_type(inj_type), .inj_len(inj_len),
    .entry_done(entry_done), .entry_fail(entry_fail),
    .timestamp_counter(timestamp_counter),
    .preempt_timer_active(preempt_timer_active),
    .preempt_tick(preempt_tick), .guest_exit(guest_exit),
    .long_mode_active_flag(long_mode_active_flag),
    .guest64_entry_ctl(guest64_entry_ctl),
    .enter_virt_operation(enter_virt_operation),
    .leave_virt_operation(leave_virt_operation),
    .trace_ctl_write(trace_ctl_write),
    .smm_monitor_ctl_bit2(smm_monitor_ctl_bit2),
    .trace_enable_clear(trace_enable_clear),
    .trace_write_fault(trace_write_fault), .smi_unblock(smi_unblock),
    .field_write_req(field_write_req), .field_encoding(field_encoding),
    .field_write_done(field_write_done),
    .field_write_fail(field_write_fail)
  );

  // Free-running clock, 50 ns period
  always #25 core_clk = ~core_clk;

  // Tick pulses are counted, so the check does not depend on exact latency
  always @(posedge core_clk)
    if (preempt_tick === 1'b1)
      tick_count++;

  // Compare a wide value
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare a single flag; unknown never matches
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({63'h0, got}, {63'h0, exp});
  endtask

  // One register access: hold the request one edge, judge the answer
  task automatic msr_access(input logic wr, input logic [31:0] idx,
    input logic flt, input logic [63:0] exp);
    @(posedge core_clk);
    msr_wr_req <= wr;
    msr_rd_req <= ~wr;
    msr_index <= idx;
    @(posedge core_clk);
    msr_wr_req <= 1'b0;
    msr_rd_req <= 1'b0;
    #1;
    chk_bit(msr_ack, ~flt);
    chk_bit(msr_fault, flt);
    chk_data(msr_rd_data, exp);
  endtask

  // Reads of every bank register but the base one, then field checks on the returned words
  task automatic test_reads;
    logic [63:0] f0;
    msr_access(1'b0, ENTRY_CTL_CAPABILITY_IDX, 1'b0, ENTRY_CTL_CAP_VAL);
    chk_data(msr_rd_data & 64'h11ff, 64'h11ff);
    msr_access(1'b0, MISC_VIRT_CAPABILITY_IDX, 1'b0, MISC_VIRT_CAP_VAL);
    chk_data(msr_rd_data & 64'h8000_3e00, 64'h0);
    chk_bit(msr_rd_data[24], ~|msr_rd_data[23:16]);
    // Bench lists stay empty, so any recommended limit is kept
    chk_data(64'(512 * (msr_rd_data[27:25] + 1)), 64'h200);
    msr_access(1'b0, CTRL_REG0_FIXED_ZERO_IDX, 1'b0, CR0_FIXED_ZERO_VAL);
    f0 = msr_rd_data;
    msr_access(1'b0, CTRL_REG0_FIXED_ONE_IDX, 1'b0, CR0_FIXED_ONE_VAL);
    chk_data(f0 & ~msr_rd_data, 64'h0);
    msr_access(1'b0, CTRL_REG4_FIXED_ZERO_IDX, 1'b0, CR4_FIXED_ZERO_VAL);
    f0 = msr_rd_data;
    msr_access(1'b0, CTRL_REG4_FIXED_ONE_IDX, 1'b0, CR4_FIXED_ONE_VAL);
    chk_data(f0 & ~msr_rd_data, 64'h0);
    msr_access(1'b0, FIELD_ENUMERATION_IDX, 1'b0, FIELD_ENUM_VAL);
    chk_data(msr_rd_data & ~64'h3fe, 64'h0);
    msr_access(1'b0, TRUE_ENTRY_CTL_IDX, 1'b0, TRUE_ENTRY_CTL_VAL);
    msr_access(1'b0, SECONDARY_EXIT_CTL_IDX, 1'b0, SEC_EXIT_CTL_VAL);
    $display("test reads done");
  endtask

  // Writes, unmapped index and the base register in and out of mode
  task automatic test_refusals;
    msr_access(1'b1, MISC_VIRT_CAPABILITY_IDX, 1'b1, SEC_EXIT_CTL_VAL);
    msr_access(1'b0, MISC_VIRT_CAPABILITY_IDX, 1'b0, MISC_VIRT_CAP_VAL);
    msr_access(1'b0, 32'h0000_048b, 1'b1, MISC_VIRT_CAP_VAL);
    msr_access(1'b0, SYS_MGMT_BASE_IDX, 1'b1, MISC_VIRT_CAP_VAL);
    system_management_mode <= 1'b1;
    msr_access(1'b0, SYS_MGMT_BASE_IDX, 1'b0, smbase_value);
    system_management_mode <= 1'b0;
    $display("test refusals done");
  endtask

  // Expected entry outcome worked out from the capability words
  function automatic logic entry_expect(input logic [31:0] c,
    input logic [31:0] p, input logic [63:0] s, input logic [1:0] a,
    input logic [2:0] t, input logic [3:0] n);
    logic [63:0] cap;
    logic bad;
    cap = BASIC_TRUE_CTLS_BIT55 ? TRUE_ENTRY_CTL_VAL :
      (ENTRY_CTL_CAP_VAL | {32'h0, ENTRY_DEFAULT_ONE});
    bad = |(~c & cap[31:0]) || |(c & ~cap[63:32]);
    bad = bad || (p[EXIT_ACT2_BIT] && |(s & ~SEC_EXIT_CTL_VAL));
    bad = bad || (a != 2'h0 && !MISC_VIRT_CAP_VAL[MISC_ACT_LSB + a - 1]);
    bad = bad || (t >= INJ_SW_INT && t <= INJ_SW_EXC && n == 4'h0 &&
      !MISC_VIRT_CAP_VAL[MISC_ZERO_LEN]);
    return bad;
  endfunction

  // One guest entry attempt, judged one cycle after it is taken
  task automatic entry_try(input logic [31:0] c, input logic [31:0] p,
    input logic [63:0] s, input logic [1:0] a, input logic [2:0] t,
    input logic [3:0] n);
    @(posedge core_clk);
    entry_req <= 1'b1;
    entry_ctls <= c;
    prim_exit_ctls <= p;
    sec_exit_ctls <= s;
    activity_state <= a;
    inj_valid <= (t != 3'h0);
    inj_type <= t;
    inj_len <= n;
    @(posedge core_clk);
    entry_req <= 1'b0;
    #1;
    chk_bit(entry_done, 1'b1);
    chk_bit(entry_fail, entry_expect(c, p, s, a, t, n));
  endtask

  // Control words, secondary exits, activity states and injections
  task automatic test_entry;
    entry_try(32'h0, 32'h0, 64'h0, 2'h0, 3'h0, 4'h1);
    entry_try(32'h4, 32'h0, 64'h0, 2'h0, 3'h0, 4'h1);
    entry_try(32'h11ff, 32'h0, 64'h0, 2'h0, 3'h0, 4'h1);
    entry_try(32'h0004_0004, 32'h0, 64'h0, 2'h0, 3'h0, 4'h1);
    entry_try(32'h0002_0004, 32'h0, 64'h0, 2'h0, 3'h0, 4'h1);
    entry_try(32'h4, 32'h8000_0000, 64'h10, 2'h0, 3'h0, 4'h1);
    entry_try(32'h4, 32'h0, 64'h10, 2'h0, 3'h0, 4'h1);
    entry_try(32'h4, 32'h8000_0000, 64'hf, 2'h0, 3'h0, 4'h1);
    for (int a = 0; a < 4; a++)
      entry_try(32'h4, 32'h0, 64'h0, 2'(a), 3'h0, 4'h1);
    for (int t = 4; t < 7; t++)
      entry_try(32'h4, 32'h0, 64'h0, 2'h0, 3'(t), 4'h0);
    $display("test entry done");
  endtask

  // Counter sweep active, then inactive; ticks follow the rate field
  task automatic test_timer;
    int x;
    int expect_ticks;
    x = int'(MISC_VIRT_CAP_VAL[4:0]);
    for (int ph = 0; ph < 2; ph++)
    begin
      @(posedge core_clk);
      preempt_timer_active <= (ph == 0);
      repeat (3) @(posedge core_clk);
      tick_count = 0;
      expect_ticks = 0;
      for (int i = 240 * ph + 1; i <= 240 * ph + 240; i++)
      begin
        @(posedge core_clk);
        timestamp_counter <= 64'(i);
        if (ph == 0 && (((i ^ (i - 1)) >> x) & 1))
          expect_ticks++;
      end
      repeat (4) @(posedge core_clk);
      chk_data(64'(tick_count), 64'(expect_ticks));
    end
    $display("test timer done");
  endtask

  // Exit stores the long-mode flag; it holds between exits
  task automatic es_step(input logic ex, input logic f, input logic exp);
    @(posedge core_clk);
    guest_exit <= ex;
    long_mode_active_flag <= f;
    @(posedge core_clk);
    guest_exit <= 1'b0;
    #1;
    chk_bit(guest64_entry_ctl, exp);
  endtask

  // One operation step, then all three event outputs judged
  task automatic op_step(input logic en, input logic lv, input logic wr,
    input logic b2, input logic clr, input logic flt, input logic unb);
    @(posedge core_clk);
    enter_virt_operation <= en;
    leave_virt_operation <= lv;
    trace_ctl_write <= wr;
    smm_monitor_ctl_bit2 <= b2;
    @(posedge core_clk);
    enter_virt_operation <= 1'b0;
    leave_virt_operation <= 1'b0;
    trace_ctl_write <= 1'b0;
    #1;
    chk_bit(trace_enable_clear, clr);
    chk_bit(trace_write_fault, flt);
    chk_bit(smi_unblock, unb);
  endtask

  // Exit store and entering, writing trace control, leaving
  task automatic test_operation;
    logic st;
    logic tr;
    st = MISC_VIRT_CAP_VAL[MISC_STORE_LMA];
    tr = TRACE_PRESENT & ~MISC_VIRT_CAP_VAL[MISC_TRACE_OK];
    es_step(1'b1, 1'b1, st);
    es_step(1'b0, 1'b0, st);
    es_step(1'b1, 1'b0, 1'b0);
    op_step(1'b1, 1'b0, 1'b0, 1'b0, tr, 1'b0, 1'b0);
    op_step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, tr, 1'b0);
    op_step(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    op_step(1'b1, 1'b0, 1'b0, 1'b0, tr, 1'b0, 1'b0);
    op_step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    op_step(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test operation done");
  endtask

  // One structure field write attempt
  task automatic fw(input logic [31:0] enc, input logic exp);
    @(posedge core_clk);
    field_write_req <= 1'b1;
    field_encoding <= enc;
    @(posedge core_clk);
    field_write_req <= 1'b0;
    #1;
    chk_bit(field_write_done, 1'b1);
    chk_bit(field_write_fail, exp);
  endtask

  // Highest index, one past it, reserved bits and exit information
  task automatic test_field_write;
    logic [31:0] top;
    top = {22'h0, FIELD_ENUM_VAL[9:1], 1'b0};
    fw(top, 1'b0);
    fw(top + 32'h2, 1'b1);
    fw(top | 32'h6001, 1'b0);
    fw(top | 32'h1000, 1'b1);
    fw(top | 32'h8000, 1'b1);
    fw(top | 32'h8000_0000, 1'b1);
    fw(top | 32'h0400, ~MISC_VIRT_CAP_VAL[MISC_ANY_WRITE]);
    $display("test field write done");
  endtask

  // Report counts and the verdict, then stop
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired at %0t", $time);
    print_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk_bit(msr_ack | msr_fault | entry_done | smi_unblock, 1'b0);
    test_reads();
    test_refusals();
    test_entry();
    test_timer();
    test_operation();
    test_field_write();
    print_verdict();
  end

endmodule

`default_nettype wire
